// File: vmg_top.v
/*
 * Code-input monitor with dual-use pin, change detect, alert and
 * general-purpose output mode, reached over a simple register port.
 * Assumes the serial-bus front end turns transactions into one-cycle
 * rd/wr strobes on ref_clk, and that the supply comparator output is
 * already synchronous to ref_clk.
 */
// How it works
// - Bit 6 selects low or high input threshold
// - Select clear: supply input, bit 5 reads 0
// - Select set: sixth code input, bit 5 live
// - Supply mode: status bit 0 reports over-limit
// - Sixth-input mode: status bit 0 reports changes
// - Flag when code differs from 11 us earlier
// - Change raises alert unless mask bit 0 set
// - Config bit 4 turns code pins into outputs
// - Code bit writes set output pin polarity
// - Config bits 3:2 steer independent pin
// - Pins 0-4 and 6, index 5 is the dual pin in sixth-input mode
// - Low bits read live code input levels
`timescale 1ns/10ps
`default_nettype none
`include "vmg_regs.vh"

module vmg_top #(
    parameter CODE_W = 5
) (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Dedicated code pins
    input wire [CODE_W-1:0] code_in,
    output reg [CODE_W-1:0] code_out,
    output reg [CODE_W-1:0] code_oe,
    // Dual-use pin, digital side
    input wire dual_pin_in,
    output reg dual_pin_out,
    output reg dual_pin_oe,
    // Independent general pin
    input wire independent_general_pin_in,
    output reg independent_general_pin_out,
    output reg independent_general_pin_oe,
    // Analog hooks
    input wire supply_over_limit,
    output reg input_threshold_select,
    output reg supply_measure_en,
    // Alert, active low
    output reg alert_n
);

    // ****************************************************************
    // Timing
    // ****************************************************************
    // Worked out as an integer, then cut to the 16-bit counter on purpose
    localparam integer CHANGE_CYC_I = `VMG_CHANGE_NS / `VMG_CLK_NS;
    localparam [15:0] CHANGE_CYC = CHANGE_CYC_I[15:0];

    // ****************************************************************
    // Storage
    // ****************************************************************
    reg [7:0] vid_pin_ctrl;
    reg [7:0] int_mask2;
    reg [7:0] config5;
    reg flag;
    reg [15:0] tick_cnt;
    reg [CODE_W:0] code_snap;
    wire [CODE_W-1:0] code_sync;
    wire dual_sync;
    wire g6_sync;
    wire sixth_mode;
    wire gp_mode;
    wire [CODE_W:0] code_now;
    wire changed;
    wire flag_set;
    wire flag_clr;
    reg [7:0] next_rdata;

    assign sixth_mode = vid_pin_ctrl[`VMG_BIT_DUALSEL];
    assign gp_mode = config5[`VMG_BIT_GP_EN];

    // Pins come from outside the clock domain
    vmg_sync #(
        .WIDTH(CODE_W + 2)
    ) u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .async_in({independent_general_pin_in, dual_pin_in, code_in}),
        .sync_out({g6_sync, dual_sync, code_sync})
    );

    // Sixth bit only joins the code in sixth-input mode
    assign code_now = {dual_sync & sixth_mode, code_sync};

    // ****************************************************************
    // Change detect
    // ****************************************************************
    // Snapshot once per interval; any mismatch with the last one flags
    // a change. A glitch shorter than the interval that returns before
    // the next snapshot is missed, which matches the documented window.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= 16'h0000;
            code_snap <= {(CODE_W + 1){1'b0}};
        end else if (tick_cnt == CHANGE_CYC - 16'h0001) begin
            tick_cnt <= 16'h0000;
            code_snap <= code_now;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    assign changed = (tick_cnt == CHANGE_CYC - 16'h0001)
        && (code_now != code_snap);

    // Status bit 0 source depends on pin function
    assign flag_set = sixth_mode ? changed : supply_over_limit;
    assign flag_clr = reg_rd && (reg_addr == `VMG_ADDR_STATUS2);

    // Sticky flag; a new event in the reading cycle survives the clear
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag <= 1'b0;
        end else if (flag_set) begin
            flag <= 1'b1;
        end else if (flag_clr) begin
            flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            vid_pin_ctrl <= `VMG_RST_VIDPIN;
            int_mask2 <= `VMG_RST_MASK2;
            config5 <= `VMG_RST_CONFIG5;
        end else if (reg_wr) begin
            case (reg_addr)
                `VMG_ADDR_VIDPIN: begin
                    vid_pin_ctrl <= reg_wdata;
                end
                `VMG_ADDR_MASK2: begin
                    int_mask2 <= reg_wdata;
                end
                `VMG_ADDR_CONFIG5: begin
                    config5 <= reg_wdata;
                end
                default: begin
                    vid_pin_ctrl <= vid_pin_ctrl;
                end
            endcase
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    // Code bits always show live pin levels, even when driven
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `VMG_ADDR_STATUS2: begin
                next_rdata[`VMG_BIT_FLAG] = flag;
            end
            `VMG_ADDR_VIDPIN: begin
                next_rdata[CODE_W-1:0] = code_sync;
                next_rdata[`VMG_BIT_SIXTH] = code_now[CODE_W];
                next_rdata[`VMG_BIT_THRESH] = vid_pin_ctrl[`VMG_BIT_THRESH];
                next_rdata[`VMG_BIT_DUALSEL] = sixth_mode;
            end
            `VMG_ADDR_MASK2: begin
                next_rdata = int_mask2;
            end
            `VMG_ADDR_CONFIG5: begin
                next_rdata = config5;
                // An undriven independent pin reports its own level
                if (!config5[`VMG_BIT_G6_DIR]) begin
                    next_rdata[`VMG_BIT_G6_LVL] = g6_sync;
                end
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ****************************************************************
    // Pins and alert
    // ****************************************************************
    // Only pins acting as code inputs become outputs; index 5 has no
    // general pin of its own, so the dual pin is driven only in
    // sixth-input mode.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            code_out <= {CODE_W{1'b0}};
            code_oe <= {CODE_W{1'b0}};
            dual_pin_out <= 1'b0;
            dual_pin_oe <= 1'b0;
            independent_general_pin_out <= 1'b0;
            independent_general_pin_oe <= 1'b0;
            input_threshold_select <= 1'b0;
            supply_measure_en <= 1'b1;
            alert_n <= 1'b1;
        end else begin
            code_out <= vid_pin_ctrl[CODE_W-1:0];
            code_oe <= {CODE_W{gp_mode}};
            dual_pin_out <= vid_pin_ctrl[`VMG_BIT_SIXTH];
            dual_pin_oe <= gp_mode & sixth_mode;
            independent_general_pin_out <=
                config5[`VMG_BIT_G6_LVL];
            independent_general_pin_oe <=
                config5[`VMG_BIT_G6_DIR];
            input_threshold_select <=
                vid_pin_ctrl[`VMG_BIT_THRESH];
            supply_measure_en <= ~sixth_mode;
            alert_n <= ~(flag & sixth_mode
                & ~int_mask2[`VMG_BIT_MASK_CHG]);
        end
    end

endmodule

`default_nettype wire

// File: vmg_regs.vh
/*
 * Register offsets, field positions, reset values and timing constants for
 * the code-input monitor and pin control block.
 * Assumes it is included by bare name from the block's design files.
 */
`ifndef VMG_REGS_VH
`define VMG_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define VMG_ADDR_STATUS2 8'h42
`define VMG_ADDR_VIDPIN 8'h43
`define VMG_ADDR_MASK2 8'h75
`define VMG_ADDR_CONFIG5 8'h7c

// ****************************************************************
// Field positions
// ****************************************************************
`define VMG_BIT_FLAG 0
`define VMG_BIT_SIXTH 5
`define VMG_BIT_THRESH 6
`define VMG_BIT_DUALSEL 7
`define VMG_BIT_MASK_CHG 0
`define VMG_BIT_GP_EN 4
`define VMG_BIT_G6_DIR 2
`define VMG_BIT_G6_LVL 3

// ****************************************************************
// Reset values
// ****************************************************************
`define VMG_RST_VIDPIN 8'h00
`define VMG_RST_MASK2 8'h00
`define VMG_RST_CONFIG5 8'h00

// ****************************************************************
// Timing: change-detect interval
// ****************************************************************
`define VMG_CHANGE_NS 11000
`define VMG_CLK_NS 20

`endif

// File: vmg_sync.v
/*
 * Two-flop synchroniser for a bus of independent levels.
 * Assumes each bit is a slow level; no bus coherence is promised.
 */
`timescale 1ns/10ps
`default_nettype none

module vmg_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // Data
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// File: vmg_top_props.sv
/* Port checker for vmg_top.
   Assumes one-cycle register strobes on ref_clk. */
`timescale 1ns/10ps
`default_nettype none
module vmg_top_props #(
    parameter CODE_W = 5
) (
    // Clock, reset, register port
    input wire ref_clk,
    input wire arst_n,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Pins
    input wire [CODE_W-1:0] code_out,
    input wire [CODE_W-1:0] code_oe,
    input wire dual_pin_oe,
    input wire supply_measure_en,
    input wire input_threshold_select,
    input wire alert_n
);
    // ****************************************
    // Write strobes, outputs land two edges on; bit 5 read data one edge on
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire rd42 = reg_rd && reg_addr == 8'h42;
    sequence s_w43; reg_wr && reg_addr == 8'h43; endsequence
    sequence s_w7c; reg_wr && reg_addr == 8'h7c; endsequence
    a_thresh_write: assert property (
        s_w43 |-> ##2 input_threshold_select == $past(reg_wdata[6], 2)
    ) else $error("threshold select wrong");
    a_sel_write: assert property (
        s_w43 |-> ##2 supply_measure_en == !$past(reg_wdata[7], 2)
    ) else $error("supply measure enable wrong");
    a_code_drive: assert property (
        s_w43 |-> ##2 code_out == $past(reg_wdata[CODE_W-1:0], 2)
    ) else $error("code drive value wrong");
    a_gp_enable: assert property (
        s_w7c |-> ##2 code_oe == {CODE_W{$past(reg_wdata[4], 2)}}
    ) else $error("code output enable wrong");
    a_dual_drive: assert property (
        s_w7c |-> ##2 dual_pin_oe ==
            ($past(reg_wdata[4], 2) && !supply_measure_en)
    ) else $error("dual pin drive enable wrong");
    a_bit5_zero: assert property (
        reg_rd && reg_addr == 8'h43 |=> reg_rdata[7] || !reg_rdata[5]
    ) else $error("bit 5 not zero in supply mode");
    // Low alert means the flag is set, unless a read or write intervened
    a_flag_read: assert property (
        !alert_n && rd42 && !$past(rd42) && !$past(reg_wr) |=> reg_rdata[0]
    ) else $error("flag clear while alert low");
    a_alert_hold: assert property (
        !alert_n && !reg_wr && !$past(reg_wr) && !rd42 && !$past(rd42)
        && !$past(rd42, 2) |=> !alert_n
    ) else $error("alert released without status read");
endmodule
bind vmg_top vmg_top_props #(.CODE_W(CODE_W)) u_props (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .code_out(code_out), .code_oe(code_oe),
    .dual_pin_oe(dual_pin_oe), .supply_measure_en(supply_measure_en),
    .input_threshold_select(input_threshold_select), .alert_n(alert_n)
);
`default_nettype wire

// File: vmg_code_src.sv
/* Processor-side model of the six code lines.
   Assumes the bench sets the wanted code; block drive wins where enabled. */
`timescale 1ns/10ps
`default_nettype none
module vmg_code_src (
    // Clock and wanted code
    input wire logic ref_clk,
    input wire logic [5:0] want,
    // Block drive
    input wire logic [5:0] oe,
    input wire logic [5:0] drv,
    // Resolved wire levels
    output logic [5:0] pin
);
    logic [5:0] lvl;
    // Code moves just after an edge, as a regulator update would
    always @(posedge ref_clk) begin
        lvl <= want;
    end
    // Lines the block drives show its value, never a stale processor level
    assign pin = (oe & drv) | (~oe & lvl);
endmodule
`default_nettype wire

// File: vid_monitor_gpio_tb_top.sv
/* Self-checking bench for vmg_top.
   Assumes vmg_top_props is bound and vmg_code_src drives the code lines. */
`timescale 1ns/10ps
`default_nettype none
module vid_monitor_gpio_tb_top;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic supply_over_limit = 1'b0;
    logic [5:0] want = 6'h00;
    logic [15:0] seed = 16'h0a47;
    logic [7:0] reg_rdata, v, d;
    logic [4:0] code_out, code_oe;
    logic dual_pin_out, dual_pin_oe, g_out, g_oe, thresh, meas, alert_n;
    logic g_in = 1'b0;
    logic [5:0] pin;
    int miscompares = 0;
    int comparisons = 0;
    // ****************************************
    // Clock, design and far side
    // ****************************************
    always #10 ref_clk = ~ref_clk;
    vmg_top DUT (
        .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .code_in(pin[4:0]), .code_out(code_out),
        .code_oe(code_oe), .dual_pin_in(pin[5]), .dual_pin_out(dual_pin_out),
        .dual_pin_oe(dual_pin_oe),
        .independent_general_pin_in(g_oe ? g_out : g_in),
        .independent_general_pin_out(g_out),
        .independent_general_pin_oe(g_oe),
        .supply_over_limit(supply_over_limit),
        .input_threshold_select(thresh),
        .supply_measure_en(meas), .alert_n(alert_n)
    );
    vmg_code_src u_src (.ref_clk(ref_clk), .want(want),
        .oe({dual_pin_oe, code_oe}), .drv({dual_pin_out, code_out}),
        .pin(pin));
    // Random source and expected read of the code register
    function automatic [15:0] nx(input [15:0] s);
        nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic [7:0] e43(input [7:0] c, input [5:0] p);
        e43 = {c[7:6], c[7] & p[5], p[4:0]};
    endfunction
    task automatic chk(input [7:0] seen, input [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input [7:0] a, input [7:0] dat);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= dat;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Data is valid from the edge that takes the strobe; it is read one edge later
    task automatic rd(input [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        #1 v = reg_rdata;
    endtask
    task automatic rc(input [7:0] a, input [7:0] e);
        rd(a);
        chk(v, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Tests take about 2600 cycles; allow over seven times that
    initial begin
        #(20 * 20000);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        rc(8'h43, 8'h00);
        rc(8'h10, 8'h00);
        chk(meas, 8'h01);
        wr(8'h43, 8'h40);
        cyc(2);
        chk(thresh, 8'h01);
        rc(8'h43, 8'h40);
        $display("threshold done");
        @(posedge ref_clk);
        want <= 6'h20;
        supply_over_limit <= 1'b1;
        @(posedge ref_clk);
        supply_over_limit <= 1'b0;
        wr(8'h43, 8'h20);
        cyc(4);
        rc(8'h43, 8'h00);
        chk(alert_n, 8'h01);
        rc(8'h42, 8'h01);
        cyc(2);
        rc(8'h42, 8'h00);
        $display("supply mode done");
        wr(8'h43, 8'hc0);
        // Corner codes all-low and all-high, then random ones
        for (int i = 0; i < 10; i++) begin
            seed = nx(seed);
            @(posedge ref_clk);
            want <= (i < 2) ? {6{i[0]}} : seed[5:0];
            cyc(4);
            rc(8'h43, e43(8'hc0, want));
        end
        $display("live levels done");
        cyc(1200);
        rd(8'h42);
        rd(8'h42);
        @(posedge ref_clk);
        want <= want ^ 6'h20;
        cyc(600);
        chk(alert_n, 8'h00);
        rc(8'h42, 8'h01);
        cyc(3);
        chk(alert_n, 8'h01);
        rc(8'h42, 8'h00);
        wr(8'h75, 8'h01);
        @(posedge ref_clk);
        want <= want ^ 6'h01;
        cyc(600);
        chk(alert_n, 8'h01);
        rc(8'h42, 8'h01);
        wr(8'h75, 8'h00);
        $display("change alert done");
        seed = nx(seed);
        d = {2'b10, seed[5:0]};
        wr(8'h7c, 8'h10);
        wr(8'h43, d);
        cyc(4);
        chk(code_oe, 8'h1f);
        chk(dual_pin_oe, 8'h01);
        chk(code_out, d[4:0]);
        chk(dual_pin_out, d[5]);
        rc(8'h43, d);
        // Every enable and level pair; an undriven pin reads the far side,
        // held opposite to the stored level so a wrong source shows
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk);
            g_in <= ~k[1];
            wr(8'h7c, {3'h0, 1'b1, k[1:0], 2'h0});
            cyc(2);
            chk({g_oe, g_out}, {k[0], k[1]});
            rc(8'h7c, {4'h1, (k[0] ? k[1] : ~k[1]), k[0], 2'h0});
        end
        wr(8'h7c, 8'h00);
        cyc(2);
        chk(code_oe, 8'h00);
        $display("general pins done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
